// file: bench/host_spi_model.sv
// Purpose: host controller that frames instructions on the link pins
// Assumes: driven from the bench clock's falling edge
// Notes: sck rests low between frames; idle io lines toggle
`timescale 1ns/1ps

module host_spi_model (
	// clock
	input wire logic clock,
	// link pins
	output logic select_n,
	output logic sck,
	output logic [3:0] io_in
);
	initial begin
		select_n = 1'b1;
		sck = 1'b0;
		io_in = 4'h0;
	end

	// 40 ns half period keeps far below every rate limit
	task automatic half();
		repeat (8) @(negedge clock);
	endtask

	task automatic shift(input logic [3:0] v);
		io_in = v;
		half();
		sck = 1'b1;
		half();
		sck = 1'b0;
	endtask

	// abort stops half way through the address
	task automatic send(input logic [7:0] code, input int nab,
		input logic [31:0] a, input int lanes, input bit abort);
		int n;
		logic [31:0] s;
		logic [3:0] mask;
		mask = 4'((1 << lanes) - 1);
		s = a << (32 - 8 * nab);
		n = 8 * nab / lanes;
		if (abort)
			n = n / 2;
		@(negedge clock);
		select_n = 1'b0;
		half();
		for (int i = 7; i >= 0; i--)
			shift({~io_in[3:1], code[i]});
		for (int i = 0; i < n; i++) begin
			shift(4'((s[31:28] >> (4 - lanes)) & mask) | (~io_in & ~mask));
			s = s << lanes;
		end
		if (!abort) begin
			shift(~io_in);
			shift(~io_in);
		end
		half();
		select_n = 1'b1;
		io_in = ~io_in;
		half();
	endtask
endmodule

// file: bench/serial_flash_command_decoder_chk.sv
// Purpose: port-level checks of the serial flash instruction decoder
// Assumes: single clock domain, asynchronous active high reset
// Notes: bound onto every instance of the decoder top
`timescale 1ns/1ps

module serial_flash_command_decoder_chk
	import flash_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// link pins
	input wire logic select_n,
	input wire logic sck,
	input wire logic [3:0] io_in,
	// bank register
	input wire logic bank_write,
	input wire logic [7:0] bank_write_data,
	input wire logic [7:0] bank_reg,
	// command stream
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire cmd_t cmd,
	input wire logic cmd_dropped,
	input wire logic selected
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	property p_bank_load;
		bank_write |=> bank_reg == $past(bank_write_data);
	endproperty
	a_bank_load: assert property (p_bank_load)
		else $error("bank register missed a load");
	// a stalled head must not move under the executor
	property p_head_hold;
		cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd);
	endproperty
	a_head_hold: assert property (p_head_hold)
		else $error("queue head changed while stalled");
	property p_known_op;
		cmd_valid |-> cmd.op != op_none;
	endproperty
	a_known_op: assert property (p_known_op)
		else $error("empty operation queued");
	property p_plain_rate;
		cmd_valid && cmd.op == plain_read |-> cmd.max_mhz == 7'd50
			&& cmd.has_addr && cmd.data_lanes == lane_one;
	endproperty
	a_plain_rate: assert property (p_plain_rate)
		else $error("plain read record wrong");
	property p_quad_page;
		cmd_valid && cmd.op == four_bit_page_write |-> cmd.max_mhz == 7'd80
			&& cmd.has_addr && cmd.data_lanes == lane_four;
	endproperty
	a_quad_page: assert property (p_quad_page)
		else $error("quad page write record wrong");
	property p_whole_wipe;
		cmd_valid && cmd.op == whole_array_wipe |-> !cmd.has_addr;
	endproperty
	a_whole_wipe: assert property (p_whole_wipe)
		else $error("whole array wipe carries an address");
	property p_quad_io;
		cmd_valid && cmd.op == four_bit_io_read |-> cmd.data_lanes == lane_four
			&& cmd.max_mhz == 7'd108;
	endproperty
	a_quad_io: assert property (p_quad_io)
		else $error("quad io read record wrong");
	property p_legacy;
		cmd_valid && cmd.op == legacy_signature_read |-> cmd.has_addr
			&& cmd.addr[31:26] == 6'h00;
	endproperty
	a_legacy: assert property (p_legacy)
		else $error("signature read address wrong");
	property p_select;
		$fell(select_n) |-> ##[1:4] selected;
	endproperty
	a_select: assert property (p_select)
		else $error("select not seen in time");
endmodule

bind serial_flash_command_decoder serial_flash_command_decoder_chk chk (
	.clock(clock), .reset(reset), .select_n(select_n), .sck(sck),
	.io_in(io_in), .bank_write(bank_write),
	.bank_write_data(bank_write_data), .bank_reg(bank_reg),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
	.cmd_dropped(cmd_dropped), .selected(selected)
);

// file: bench/tb_serial_flash_command_decoder.sv
// Purpose: self-checking bench of the serial flash instruction decoder
// Assumes: host_spi_model drives the link pins
// Notes: every code runs with the wide flag clear and then set
`timescale 1ns/1ps

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	n_errors++; $display("wrong value at %0t: got %h expected %h", \
	$time, got, exp); end end

module tb_serial_flash_command_decoder
	import flash_pkg::*;
;
	logic clock = 1'b0;
	logic reset, bank_write, cmd_ready, cmd_valid, cmd_dropped, selected;
	logic select_n, sck;
	logic [3:0] io_in;
	logic [7:0] bank_write_data, bank_reg, bank;
	cmd_t cmd, e;
	int n_errors = 0;
	int comparisons = 0;
	int n_drop = 0;
	logic [7:0] codes [32] = '{8'h90, 8'h9f, 8'h05, 8'h07, 8'h35, 8'h30,
		8'h41, 8'h43, 8'h4a, 8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b,
		8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec, 8'h02, 8'h12, 8'h32, 8'h38, 8'h34,
		8'h20, 8'h21, 8'h60, 8'hc7, 8'hd8, 8'hdc};

	always #2.5 clock = ~clock;

	host_spi_model host (.clock(clock), .select_n(select_n), .sck(sck),
		.io_in(io_in));

	serial_flash_command_decoder dut (.clock(clock), .reset(reset),
		.select_n(select_n), .sck(sck), .io_in(io_in),
		.bank_write(bank_write), .bank_write_data(bank_write_data),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.bank_reg(bank_reg), .cmd_dropped(cmd_dropped), .selected(selected));

	always @(posedge clock)
		if (cmd_dropped === 1'b1)
			n_drop++;

	function automatic int nbytes(input logic [7:0] c, input logic [7:0] b);
		case (c)
			8'h90: return 3;
			8'h9f, 8'h05, 8'h07, 8'h35, 8'h30, 8'h41, 8'h43, 8'h4a, 8'h60,
			8'hc7: return 0;
			8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc, 8'hec, 8'h12, 8'h34, 8'h21,
			8'hdc: return 4;
			default: return b[7] ? 4 : 3;
		endcase
	endfunction

	function automatic cmd_t expect_cmd(input logic [7:0] c,
		input logic [7:0] b, input logic [31:0] a);
		cmd_t r;
		case (c)
			8'h90: r.op = legacy_signature_read;
			8'h9f: r.op = standard_id_read;
			8'h05: r.op = status_one_read;
			8'h07: r.op = status_two_read;
			8'h35: r.op = config_one_read;
			8'h30: r.op = fail_flags_clear;
			8'h41: r.op = learning_pattern_read;
			8'h43: r.op = learning_pattern_nv_program;
			8'h4a: r.op = learning_pattern_volatile_write;
			8'h03, 8'h13: r.op = plain_read;
			8'h0b, 8'h0c: r.op = latency_read;
			8'h3b, 8'h3c: r.op = two_bit_out_read;
			8'h6b, 8'h6c: r.op = four_bit_out_read;
			8'hbb, 8'hbc: r.op = two_bit_io_read;
			8'heb, 8'hec: r.op = four_bit_io_read;
			8'h02, 8'h12: r.op = page_write;
			8'h32, 8'h38, 8'h34: r.op = four_bit_page_write;
			8'h20, 8'h21: r.op = small_sector_wipe;
			8'h60, 8'hc7: r.op = whole_array_wipe;
			default: r.op = large_sector_wipe;
		endcase
		r.has_addr = nbytes(c, b) != 0;
		r.addr = nbytes(c, b) == 3 ? {6'h00, b[1:0], a[23:0]} : a;
		r.data_lanes = c inside {8'h3b, 8'h3c, 8'hbb, 8'hbc} ? lane_two :
			c inside {8'h6b, 8'h6c, 8'heb, 8'hec, 8'h32, 8'h38, 8'h34} ?
			lane_four : lane_one;
		r.max_mhz = c inside {8'h03, 8'h13} ? 7'h32 :
			c inside {8'h32, 8'h38, 8'h34} ? 7'h50 : 7'h6c;
		return r;
	endfunction

	task automatic wait_valid();
		int k;
		k = 0;
		while (cmd_valid !== 1'b1 && k < 200) begin
			@(negedge clock);
			k++;
		end
		`CHK(cmd_valid, 1'b1)
	endtask

	// random stall first, so the head has to hold; at least one edge
	// passes so ready drops between two pops
	task automatic pop();
		repeat (1 + $urandom % 4) @(negedge clock);
		cmd_ready = 1'b1;
		@(negedge clock);
		cmd_ready = 1'b0;
	endtask

	task automatic run_one(input logic [7:0] c);
		logic [31:0] a;
		int ln;
		a = $urandom;
		e = expect_cmd(c, bank, a);
		ln = c inside {8'hbb, 8'hbc} ? 2 : c inside {8'heb, 8'hec} ? 4 : 1;
		host.send(c, nbytes(c, bank), a, ln, 1'b0);
		wait_valid();
		`CHK(cmd.op, e.op)
		`CHK(cmd.has_addr, e.has_addr)
		if (e.has_addr)
			`CHK(cmd.addr, e.addr)
		`CHK(cmd.data_lanes, e.data_lanes)
		`CHK(cmd.max_mhz, e.max_mhz)
		pop();
		`CHK(cmd_valid, 1'b0)
	endtask

	task automatic print_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#500000;
		n_errors++;
		print_verdict();
	end

	initial begin
		reset = 1'b1;
		bank_write = 1'b0;
		bank_write_data = 8'h00;
		cmd_ready = 1'b0;
		void'($urandom(32'h70a069ca));
		repeat (16) @(posedge clock);
		@(negedge clock);
		reset = 1'b0;
		repeat (4) @(negedge clock);
		`CHK(bank_reg, 8'h00)
		`CHK(cmd_valid, 1'b0)
		for (int p = 0; p < 2; p++) begin
			bank = p ? {1'b1, 5'h00, 2'($urandom)} : 8'h00;
			bank_write = 1'b1;
			bank_write_data = bank;
			@(negedge clock);
			bank_write = 1'b0;
			bank_write_data = 8'($urandom);
			foreach (codes[i])
				run_one(codes[i]);
		end
		// unknown codes, then an address cut short by select
		foreach (codes[i]) begin
			if (i < 3) begin
				host.send(i == 0 ? 8'hab : i == 1 ? 8'hff : 8'h18, 0, 0, 1, 0);
				repeat (40) @(negedge clock);
				`CHK(cmd_valid, 1'b0)
			end
		end
		host.send(8'h03, 4, $urandom, 1, 1'b1);
		repeat (40) @(negedge clock);
		`CHK(cmd_valid, 1'b0)
		// overfill with the executor stalled: 16 queued, one waits
		repeat (18)
			host.send(8'h05, 0, 0, 1, 1'b0);
		repeat (10) @(negedge clock);
		`CHK(n_drop, 1)
		repeat (17) begin
			wait_valid();
			`CHK(cmd.op, status_one_read)
			pop();
		end
		`CHK(cmd_valid, 1'b0)
		print_verdict();
	end
endmodule

// file: verilog/flash_defs.svh
// Purpose: named constants of the serial flash instruction decoder
// Assumes: included by its bare name from the package only
// Notes: instruction codes are eight bits, shifted in msb first
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH

// ****************************************************************
// instruction codes
// ****************************************************************
`define CODE_LEGACY_SIG 8'h90
`define CODE_STD_ID 8'h9f
`define CODE_STATUS1_RD 8'h05
`define CODE_STATUS2_RD 8'h07
`define CODE_CONFIG1_RD 8'h35
`define CODE_FAIL_CLR 8'h30
`define CODE_LEARN_RD 8'h41
`define CODE_LEARN_NV 8'h43
`define CODE_LEARN_VOL 8'h4a
`define CODE_READ 8'h03
`define CODE_READ_W 8'h13
`define CODE_FAST 8'h0b
`define CODE_FAST_W 8'h0c
`define CODE_DOUT 8'h3b
`define CODE_DOUT_W 8'h3c
`define CODE_QOUT 8'h6b
`define CODE_QOUT_W 8'h6c
`define CODE_DIO 8'hbb
`define CODE_DIO_W 8'hbc
`define CODE_QIO 8'heb
`define CODE_QIO_W 8'hec
`define CODE_PAGE 8'h02
`define CODE_PAGE_W 8'h12
`define CODE_QPAGE 8'h32
`define CODE_QPAGE_ALT 8'h38
`define CODE_QPAGE_W 8'h34
`define CODE_SMALL_WIPE 8'h20
`define CODE_SMALL_WIPE_W 8'h21
`define CODE_ALL_WIPE 8'h60
`define CODE_ALL_WIPE_ALT 8'hc7
`define CODE_LARGE_WIPE 8'hd8
`define CODE_LARGE_WIPE_W 8'hdc

// ****************************************************************
// bank register, counts and rate limits
// ****************************************************************
`define BANK_RESET 8'h00
`define BANK_WIDE_BIT 7
`define BANK_SEL_HI 1
`define BANK_HIGH_PAD 6'h00
`define INSTR_BITS 6'd8
`define ADDR_BITS_3B 6'd24
`define ADDR_BITS_4B 6'd32
`define BIT_COUNT_ZERO 6'd0
`define BIT_STEP_1 6'd1
`define BIT_STEP_2 6'd2
`define BIT_STEP_4 6'd4
`define RATE_DEFAULT_MHZ 7'd108
`define RATE_PLAIN_READ_MHZ 7'd50
`define RATE_QUAD_PAGE_MHZ 7'd80
`define FIFO_DEPTH 16

`endif

// file: verilog/flash_pkg.sv
// Purpose: types shared by the serial flash instruction decoder
// Assumes: flash_defs.svh provides the numeric constants
// Notes: op codes are internal, not the wire instruction values
package flash_pkg;
`include "flash_defs.svh"

	typedef enum logic [4:0] {
		op_none = 5'b00000,
		legacy_signature_read = 5'b00001,
		standard_id_read = 5'b00010,
		status_one_read = 5'b00011,
		status_two_read = 5'b00100,
		config_one_read = 5'b00101,
		fail_flags_clear = 5'b00110,
		learning_pattern_read = 5'b00111,
		learning_pattern_nv_program = 5'b01000,
		learning_pattern_volatile_write = 5'b01001,
		plain_read = 5'b01010,
		latency_read = 5'b01011,
		two_bit_out_read = 5'b01100,
		four_bit_out_read = 5'b01101,
		two_bit_io_read = 5'b01110,
		four_bit_io_read = 5'b01111,
		page_write = 5'b10000,
		four_bit_page_write = 5'b10001,
		small_sector_wipe = 5'b10010,
		whole_array_wipe = 5'b10011,
		large_sector_wipe = 5'b10100
	} op_t;

	typedef enum logic [1:0] {
		lane_one = 2'b00,
		lane_two = 2'b01,
		lane_four = 2'b10
	} lane_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_instr = 2'b01,
		st_addr = 2'b10,
		st_done = 2'b11
	} phase_t;

	// one decoded command as handed to the executor
	typedef struct packed {
		op_t op;
		logic has_addr;
		logic [31:0] addr;
		lane_t data_lanes;
		logic [6:0] max_mhz;
	} cmd_t;
endpackage

// file: verilog/serial_flash_command_decoder.sv
// Purpose: decode serial flash instructions and addresses into commands
// Assumes: link pins are asynchronous; the 200 MHz clock oversamples sck
// Notes: data phases are left to the executor that drains the queue
//
// What this block does
// - bank bits both zero select bank 0, bytes 00000000 to 00ffffff.
// - 90 hex is the legacy signature read, clocked up to 108 MHz.
// - 9f hex is the standard identification read with flash interface data.
// - 05, 07, 35 hex read status one, status two, configuration one.
// - 30 hex clears the program and erase failure flags.
// - 41 reads learning pattern; 43 programs nv copy; 4a writes volatile.
// - 03 hex is the zero latency single read, at most 50 MHz.
// - 0b fast read with flag-chosen address; 0c fast read, four bytes.
// - 3b hex reads data two bits per clock, flag-chosen address.
// - 6b reads four bits per clock; 6c same with four byte address.
// - bb dual address and data read; bc same with four bytes.
// - eb quad address and data read; ec same with four bytes.
// - 02 page write with flag-chosen address; 12 with four bytes.
// - 32 and 38 quad page write, 34 four byte form; 80 MHz max.
// - 20 small sector wipe, flag-chosen address; 21 with four bytes.
// - 60 and c7 both wipe the whole array.
// - d8 large sector wipe, flag-chosen address; dc with four bytes.
// - wide address flag clears at reset; when set legacy codes other than 90 take four.
// - eight bit instruction first; bits msb first; address msb byte first.
// - select low before first rising clock; raising select ends command.
// - three byte commands take the top address byte from bank register bits 1:0, zero padded above.
`timescale 1ns/1ps

// ****************************************************************
// command queue
// ****************************************************************
module cmd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr, rd_ptr;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire empty = (wr_ptr == rd_ptr);
	wire full = (wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge clock) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// ****************************************************************
// instruction decoder top
// ****************************************************************
module serial_flash_command_decoder
	import flash_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// serial link pins from the host
	input wire logic select_n,
	input wire logic sck,
	input wire logic [3:0] io_in,
	// bank register update from the register executor
	input wire logic bank_write,
	input wire logic [7:0] bank_write_data,
	// decoded command stream
	output logic cmd_valid,
	input wire logic cmd_ready,
	output cmd_t cmd,
	// status
	output logic [7:0] bank_reg,
	output logic cmd_dropped,
	output logic selected
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [5:0] pin_meta, pin_sync;
	logic sck_prev;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pin_meta <= 6'h3f;
			pin_sync <= 6'h3f;
			sck_prev <= 1'b1; // matches the synced reset level: no false rise
		end else begin
			pin_meta <= {select_n, sck, io_in};
			pin_sync <= pin_meta;
			sck_prev <= pin_sync[4];
		end
	end

	wire sel_n_s = pin_sync[5];
	wire sck_s = pin_sync[4];
	wire [3:0] io_s = pin_sync[3:0];
	wire link_edge = sck_s && !sck_prev && !sel_n_s;

	// ************************************************************
	// bank register
	// ************************************************************
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			bank_reg <= `BANK_RESET;
		else if (bank_write)
			bank_reg <= bank_write_data;
	end

	wire wide_address_flag = bank_reg[`BANK_WIDE_BIT];

	// ************************************************************
	// shifting and phase control
	// ************************************************************
	phase_t phase, next_phase;
	logic [5:0] bit_count;
	logic [7:0] instr;
	logic [31:0] addr_shift;
	op_t cur_op;
	logic cur_wide;
	lane_t cur_addr_lanes, cur_data_lanes;
	logic [6:0] cur_mhz;

	// decode of the byte as it completes (shift plus incoming bit)
	wire [7:0] instr_next = {instr[6:0], io_s[0]};
	op_t dec_op;
	logic dec_addr;
	logic dec_fixed_wide;
	lane_t dec_addr_lanes, dec_data_lanes;
	logic [6:0] dec_mhz;

	always_comb begin
		dec_op = op_none;
		dec_addr = 1'b0;
		dec_fixed_wide = 1'b0;
		dec_addr_lanes = lane_one;
		dec_data_lanes = lane_one;
		dec_mhz = `RATE_DEFAULT_MHZ;
		unique case (instr_next)
			`CODE_LEGACY_SIG: begin
				dec_op = legacy_signature_read;
				dec_addr = 1'b1;
			end
			`CODE_STD_ID: dec_op = standard_id_read;
			`CODE_STATUS1_RD: dec_op = status_one_read;
			`CODE_STATUS2_RD: dec_op = status_two_read;
			`CODE_CONFIG1_RD: dec_op = config_one_read;
			`CODE_FAIL_CLR: dec_op = fail_flags_clear;
			`CODE_LEARN_RD: dec_op = learning_pattern_read;
			`CODE_LEARN_NV: dec_op = learning_pattern_nv_program;
			`CODE_LEARN_VOL: dec_op = learning_pattern_volatile_write;
			`CODE_READ, `CODE_READ_W: begin
				dec_op = plain_read;
				dec_addr = 1'b1;
				dec_fixed_wide = (instr_next == `CODE_READ_W);
				dec_mhz = `RATE_PLAIN_READ_MHZ;
			end
			`CODE_FAST, `CODE_FAST_W: begin
				dec_op = latency_read;
				dec_addr = 1'b1;
				dec_fixed_wide = (instr_next == `CODE_FAST_W);
			end
			`CODE_DOUT, `CODE_DOUT_W: begin
				dec_op = two_bit_out_read;
				dec_addr = 1'b1;
				dec_fixed_wide = (instr_next == `CODE_DOUT_W);
				dec_data_lanes = lane_two;
			end
			`CODE_QOUT, `CODE_QOUT_W: begin
				dec_op = four_bit_out_read;
				dec_addr = 1'b1;
				dec_fixed_wide = (instr_next == `CODE_QOUT_W);
				dec_data_lanes = lane_four;
			end
			`CODE_DIO, `CODE_DIO_W: begin
				dec_op = two_bit_io_read;
				dec_addr = 1'b1;
				dec_fixed_wide = (instr_next == `CODE_DIO_W);
				dec_addr_lanes = lane_two;
				dec_data_lanes = lane_two;
			end
			`CODE_QIO, `CODE_QIO_W: begin
				dec_op = four_bit_io_read;
				dec_addr = 1'b1;
				dec_fixed_wide = (instr_next == `CODE_QIO_W);
				dec_addr_lanes = lane_four;
				dec_data_lanes = lane_four;
			end
			`CODE_PAGE, `CODE_PAGE_W: begin
				dec_op = page_write;
				dec_addr = 1'b1;
				dec_fixed_wide = (instr_next == `CODE_PAGE_W);
			end
			`CODE_QPAGE, `CODE_QPAGE_ALT, `CODE_QPAGE_W: begin
				dec_op = four_bit_page_write;
				dec_addr = 1'b1;
				dec_fixed_wide = (instr_next == `CODE_QPAGE_W);
				dec_data_lanes = lane_four;
				dec_mhz = `RATE_QUAD_PAGE_MHZ;
			end
			`CODE_SMALL_WIPE, `CODE_SMALL_WIPE_W: begin
				dec_op = small_sector_wipe;
				dec_addr = 1'b1;
				dec_fixed_wide = (instr_next == `CODE_SMALL_WIPE_W);
			end
			`CODE_ALL_WIPE, `CODE_ALL_WIPE_ALT:
				dec_op = whole_array_wipe;
			`CODE_LARGE_WIPE, `CODE_LARGE_WIPE_W: begin
				dec_op = large_sector_wipe;
				dec_addr = 1'b1;
				dec_fixed_wide = (instr_next == `CODE_LARGE_WIPE_W);
			end
			default: dec_op = op_none;
		endcase
	end

	// the signature read always takes three bytes in this decoder
	wire dec_wide = dec_fixed_wide ||
		(wide_address_flag && dec_op != legacy_signature_read);
	// address bits per edge and total address bits for the address phase
	wire [5:0] addr_step = (cur_addr_lanes == lane_four) ? `BIT_STEP_4 :
		(cur_addr_lanes == lane_two) ? `BIT_STEP_2 : `BIT_STEP_1;
	wire [5:0] addr_total = cur_wide ? `ADDR_BITS_4B : `ADDR_BITS_3B;
	wire [5:0] bit_count_step = bit_count + addr_step;
	wire addr_last = link_edge && (bit_count_step == addr_total);
	wire instr_last = link_edge && (bit_count == `INSTR_BITS - 6'd1);
	// msb first on every lane group
	wire [31:0] addr_next =
		(cur_addr_lanes == lane_four) ? {addr_shift[27:0], io_s} :
		(cur_addr_lanes == lane_two) ? {addr_shift[29:0], io_s[1:0]} :
		{addr_shift[30:0], io_s[0]};

	// the bank value is applied to the start address only
	wire [31:0] addr_full = cur_wide ? addr_next :
		{`BANK_HIGH_PAD, bank_reg[`BANK_SEL_HI:0], addr_next[23:0]};

	always_comb begin
		next_phase = phase;
		unique case (phase)
			st_idle:
				if (!sel_n_s)
					next_phase = st_instr;
			st_instr:
				if (instr_last)
					next_phase = (dec_addr && dec_op != op_none) ?
						st_addr : st_done;
			st_addr:
				if (addr_last)
					next_phase = st_done;
			st_done:
				next_phase = st_done;
		endcase
		if (sel_n_s)
			next_phase = st_idle;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			phase <= st_idle;
		else
			phase <= next_phase;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			bit_count <= `BIT_COUNT_ZERO;
			instr <= 8'h00;
			addr_shift <= 32'h0000_0000;
		end else if (phase == st_idle || sel_n_s) begin
			bit_count <= `BIT_COUNT_ZERO;
		end else if (phase == st_instr && link_edge) begin
			instr <= instr_next;
			bit_count <= instr_last ? `BIT_COUNT_ZERO :
				bit_count + `BIT_STEP_1;
		end else if (phase == st_addr && link_edge) begin
			addr_shift <= addr_next;
			bit_count <= bit_count_step;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cur_op <= op_none;
			cur_wide <= 1'b0;
			cur_addr_lanes <= lane_one;
			cur_data_lanes <= lane_one;
			cur_mhz <= `RATE_DEFAULT_MHZ;
		end else if (phase == st_instr && instr_last) begin
			cur_op <= dec_op;
			cur_wide <= dec_wide;
			cur_addr_lanes <= dec_addr_lanes;
			cur_data_lanes <= dec_data_lanes;
			cur_mhz <= dec_mhz;
		end
	end

	// ************************************************************
	// hand-off to the queue
	// ************************************************************
	// the link cannot be paused, so a command that finds the hand-off
	// slot occupied while the queue is full is dropped and reported
	wire instr_done = phase == st_instr && instr_last &&
		dec_op != op_none && !dec_addr;
	wire addr_done = phase == st_addr && addr_last;
	wire done = instr_done || addr_done;
	logic pend;
	cmd_t pend_cmd;
	logic fifo_in_ready;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pend <= 1'b0;
			pend_cmd <= '0;
			cmd_dropped <= 1'b0;
		end else begin
			cmd_dropped <= done && pend && !fifo_in_ready;
			if (done && (!pend || fifo_in_ready)) begin
				pend <= 1'b1;
				pend_cmd.op <= instr_done ? dec_op : cur_op;
				pend_cmd.has_addr <= addr_done;
				pend_cmd.addr <= addr_done ? addr_full : 32'h0000_0000;
				pend_cmd.data_lanes <= instr_done ? dec_data_lanes :
					cur_data_lanes;
				pend_cmd.max_mhz <= instr_done ? dec_mhz : cur_mhz;
			end else if (fifo_in_ready) begin
				pend <= 1'b0;
			end
		end
	end

	cmd_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(`FIFO_DEPTH)) queue (
		.clock(clock), .reset(reset),
		.in_valid(pend), .in_ready(fifo_in_ready), .in_data(pend_cmd),
		.out_valid(cmd_valid), .out_ready(cmd_ready), .out_data(cmd)
	);

	assign selected = !sel_n_s;
endmodule
